//--- rtl/pdrc_top.sv
// Purpose: power-down and reset control of the hands-free voice processor
// Assumes: single clock core_clk, synchronous active-high reset
// Notes: pins pass the three-stage synchroniser before use
//
// Notes on behaviour
// - low reset pin forces the device into power-down
// - power-down clears control bits, internal variables and canceler state
// - after power-down release the device starts in initial mode
// - effective reset is low reset pin or the soft reset bit
// - high sleep pin powers down only the line codec
// - line codec power-down is sleep pin OR line off bit
// - powered-down line codec leaves its outputs high impedance
// - acoustic gain output is high impedance during power-down reset
// - line serial output is high impedance in power-down and initial mode
`timescale 1ns/100ps
module pdrc_top #(
    parameter int HOLD_CYCLES = pdrc_pkg::RESET_HOLD_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic power_down_reset_n,
    input wire logic line_codec_sleep,
    input wire logic [pdrc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [pdrc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [pdrc_pkg::DATA_W-1:0] reg_rdata,
    output logic core_reset,
    output logic canceler_clear,
    output logic initial_mode,
    output logic normal_mode,
    output logic line_codec_power_down,
    output logic line_codec_out_oe_n,
    output logic acoustic_gain_oe_n,
    output logic line_serial_oe_n
);

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic pin_rst_n_f;
    logic pin_sleep_f;

    // the reset pin is taken as asserted until it has been seen high
    pdrc_pin_sync #(
        .WIDTH(2),
        .INIT(2'h0)
    ) u_pin_sync (
        .core_clk(core_clk),
        .reset(reset),
        .pin_in({line_codec_sleep, power_down_reset_n}),
        .level_q({pin_sleep_f, pin_rst_n_f})
    );

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        pdrc_pkg::pdrc_state_e state;
        logic [pdrc_pkg::DATA_W-1:0] ctrl;
        logic [pdrc_pkg::HOLD_W-1:0] hold;
        logic [pdrc_pkg::DATA_W-1:0] rdata;
        logic core_reset;
        logic initial_mode;
        logic normal_mode;
        logic line_pd;
        logic line_oe_n;
        logic gain_oe_n;
        logic serial_oe_n;
    } pdrc_regs_s;

    pdrc_regs_s st_q;
    pdrc_regs_s st_d;
    logic eff_reset;
    logic [pdrc_pkg::DATA_W-1:0] status;
    logic [pdrc_pkg::HOLD_W-1:0] hold_load;

    assign hold_load = pdrc_pkg::HOLD_W'(HOLD_CYCLES - 1);

    // the soft bit is cleared by the reset it causes, so it self-clears
    assign eff_reset = !pin_rst_n_f
        || st_q.ctrl[pdrc_pkg::SOFT_RESET_POS];

    always_comb begin
        status = '0;
        status[pdrc_pkg::ST_PD_POS] =
            (st_q.state == pdrc_pkg::PDRC_POWER_DOWN);
        status[pdrc_pkg::ST_INIT_POS] = st_q.initial_mode;
        status[pdrc_pkg::ST_NORMAL_POS] = st_q.normal_mode;
        status[pdrc_pkg::ST_LINE_PD_POS] = st_q.line_pd;
        status[pdrc_pkg::ST_PIN_RST_POS] = pin_rst_n_f;
        status[pdrc_pkg::ST_PIN_SLEEP_POS] = pin_sleep_f;
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        st_d = st_q;

        // register writes; ignored while held in power-down
        if (reg_wr && reg_addr == pdrc_pkg::MAIN_CTRL_ADDR
                && st_q.state != pdrc_pkg::PDRC_POWER_DOWN) begin
            st_d.ctrl = reg_wdata & pdrc_pkg::MAIN_CTRL_MASK;
        end

        case (st_q.state)
            pdrc_pkg::PDRC_POWER_DOWN: begin
                // stretch so a one-cycle soft reset still clears everything
                if (st_q.hold != '0) begin
                    st_d.hold = st_q.hold - 1'b1;
                end else begin
                    st_d.state = pdrc_pkg::PDRC_INITIAL;
                end
            end
            pdrc_pkg::PDRC_INITIAL: begin
                if (st_q.ctrl[pdrc_pkg::RUN_POS]) begin
                    st_d.state = pdrc_pkg::PDRC_NORMAL;
                end
            end
            pdrc_pkg::PDRC_NORMAL: begin
                st_d.state = pdrc_pkg::PDRC_NORMAL;
            end
            default: begin
                st_d.state = pdrc_pkg::PDRC_POWER_DOWN;
            end
        endcase

        if (eff_reset) begin
            st_d.state = pdrc_pkg::PDRC_POWER_DOWN;
            st_d.ctrl = pdrc_pkg::MAIN_CTRL_RESET;
            st_d.hold = hold_load;
        end

        // one flop drives core_reset and canceler_clear; the output enables have flops of their own
        st_d.core_reset =
            (st_d.state == pdrc_pkg::PDRC_POWER_DOWN);
        st_d.initial_mode = (st_d.state == pdrc_pkg::PDRC_INITIAL);
        st_d.normal_mode = (st_d.state == pdrc_pkg::PDRC_NORMAL);
        st_d.line_pd = pin_sleep_f
            || st_d.ctrl[pdrc_pkg::LINE_OFF_POS];
        st_d.line_oe_n = st_d.line_pd || st_d.core_reset;
        st_d.gain_oe_n = st_d.core_reset;
        st_d.serial_oe_n = !st_d.normal_mode;

        st_d.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                pdrc_pkg::MAIN_CTRL_ADDR: st_d.rdata = st_q.ctrl;
                pdrc_pkg::STATUS_ADDR: st_d.rdata = status;
                default: st_d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_q.state <= pdrc_pkg::PDRC_POWER_DOWN;
            st_q.ctrl <= pdrc_pkg::MAIN_CTRL_RESET;
            st_q.hold <= '0;
            st_q.rdata <= '0;
            st_q.core_reset <= 1'b1;
            st_q.initial_mode <= 1'b0;
            st_q.normal_mode <= 1'b0;
            st_q.line_pd <= 1'b0;
            st_q.line_oe_n <= 1'b1;
            st_q.gain_oe_n <= 1'b1;
            st_q.serial_oe_n <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign reg_rdata = st_q.rdata;
    assign core_reset = st_q.core_reset;
    assign canceler_clear = st_q.core_reset;
    assign initial_mode = st_q.initial_mode;
    assign normal_mode = st_q.normal_mode;
    assign line_codec_power_down = st_q.line_pd;
    assign line_codec_out_oe_n = st_q.line_oe_n;
    assign acoustic_gain_oe_n = st_q.gain_oe_n;
    assign line_serial_oe_n = st_q.serial_oe_n;

    // ****************************************************************
    // assertions: reset and operating modes
    // ****************************************************************
    a_pin_forces_pd: assert property (@(posedge core_clk)
        disable iff (reset)
        !pin_rst_n_f |=> st_q.state == pdrc_pkg::PDRC_POWER_DOWN
            && core_reset)
        else $error("reset pin low did not force power-down");

    a_pd_modes_off: assert property (@(posedge core_clk)
        disable iff (reset)
        core_reset |-> !initial_mode && !normal_mode)
        else $error("operating mode shown during power-down");

    a_ctrl_cleared: assert property (@(posedge core_clk)
        disable iff (reset)
        eff_reset |=> st_q.ctrl == '0 && canceler_clear)
        else $error("control bits not cleared by reset");

    // writes are ignored in power-down, so the bits stay clear throughout
    a_pd_ctrl_zero: assert property (@(posedge core_clk)
        disable iff (reset)
        core_reset |-> st_q.ctrl == '0)
        else $error("control bits set during power-down");

    a_release_initial: assert property (@(posedge core_clk)
        disable iff (reset)
        ($past(st_q.state) == pdrc_pkg::PDRC_POWER_DOWN
            && st_q.state != pdrc_pkg::PDRC_POWER_DOWN)
        |-> initial_mode && !normal_mode)
        else $error("release did not enter initial mode");

    a_init_waits_run: assert property (@(posedge core_clk)
        disable iff (reset)
        (initial_mode && !st_q.ctrl[pdrc_pkg::RUN_POS] && !eff_reset)
        |=> initial_mode)
        else $error("initial mode left without run request");

    a_soft_reset: assert property (@(posedge core_clk)
        disable iff (reset)
        (reg_wr && reg_addr == pdrc_pkg::MAIN_CTRL_ADDR
            && reg_wdata[pdrc_pkg::SOFT_RESET_POS] && !core_reset)
        |=> ##1 core_reset)
        else $error("soft reset bit did not reset");

    a_soft_bit_clear: assert property (@(posedge core_clk)
        disable iff (reset)
        st_q.ctrl[pdrc_pkg::SOFT_RESET_POS]
        |=> core_reset && !st_q.ctrl[pdrc_pkg::SOFT_RESET_POS])
        else $error("soft reset bit did not clear itself");

    a_hold_release: assert property (@(posedge core_clk)
        disable iff (reset)
        (core_reset && !st_d.core_reset) |-> st_q.hold == '0
            && !eff_reset)
        else $error("reset released before hold elapsed");

    a_hold_counts: assert property (@(posedge core_clk)
        disable iff (reset)
        (core_reset && !eff_reset && st_q.hold != '0)
        |=> core_reset && st_q.hold == $past(st_q.hold) - 1'b1)
        else $error("reset hold did not count down");

    a_release_aligned: assert property (@(posedge core_clk)
        disable iff (reset)
        $fell(core_reset) |-> !canceler_clear && !acoustic_gain_oe_n
            && initial_mode)
        else $error("outputs left reset on different edges");

    // ****************************************************************
    // assertions: line codec and output enables
    // ****************************************************************
    a_line_pd_pin: assert property (@(posedge core_clk)
        disable iff (reset)
        pin_sleep_f |=> line_codec_power_down && line_codec_out_oe_n)
        else $error("sleep pin did not power down line codec");

    a_line_pd_bit: assert property (@(posedge core_clk)
        disable iff (reset)
        (!pin_sleep_f && !st_q.ctrl[pdrc_pkg::LINE_OFF_POS]
            && !eff_reset && !reg_wr)
        |=> !line_codec_power_down)
        else $error("line codec down with no request");

    a_line_off_bit: assert property (@(posedge core_clk)
        disable iff (reset)
        st_q.ctrl[pdrc_pkg::LINE_OFF_POS] |-> line_codec_power_down)
        else $error("line off bit did not power down line codec");

    a_line_hiz: assert property (@(posedge core_clk)
        disable iff (reset)
        line_codec_power_down |-> line_codec_out_oe_n)
        else $error("line codec output driven while powered down");

    a_line_driven: assert property (@(posedge core_clk)
        disable iff (reset)
        (!line_codec_power_down && !core_reset) |-> !line_codec_out_oe_n)
        else $error("line codec output idle while running");

    a_gain_hiz: assert property (@(posedge core_clk)
        disable iff (reset)
        core_reset |-> acoustic_gain_oe_n && line_codec_out_oe_n)
        else $error("gain output driven in power-down");

    a_gain_driven: assert property (@(posedge core_clk)
        disable iff (reset)
        !core_reset |-> !acoustic_gain_oe_n)
        else $error("gain output released outside power-down");

    a_serial_hiz: assert property (@(posedge core_clk)
        disable iff (reset)
        (core_reset || initial_mode) |-> line_serial_oe_n)
        else $error("line serial output driven before normal mode");

    a_serial_driven: assert property (@(posedge core_clk)
        disable iff (reset)
        normal_mode |-> !line_serial_oe_n)
        else $error("line serial output idle in normal mode");

    // ****************************************************************
    // assertions: register port
    // ****************************************************************
    a_rdata_idle: assert property (@(posedge core_clk)
        disable iff (reset)
        !reg_rd |=> reg_rdata == '0)
        else $error("read data shown without a read strobe");

endmodule // pdrc_top

//--- rtl/pdrc_pkg.sv
// Purpose: shared constants and types of the power-down and reset control
// Assumes: core_clk at 50 MHz, an 8-bit register port with 4-bit addresses
// Notes: the register offsets and status layout are local choices
package pdrc_pkg;

    // ****************************************************************
    // register port
    // ****************************************************************
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [3:0] MAIN_CTRL_ADDR = 4'h0;
    localparam logic [3:0] STATUS_ADDR = 4'h1;

    // ****************************************************************
    // main control register fields
    // ****************************************************************
    localparam int RUN_POS = 0;
    localparam int LINE_OFF_POS = 5;
    localparam int SOFT_RESET_POS = 7;
    localparam logic [7:0] MAIN_CTRL_RESET = 8'h00;
    // writable bits; the others read as zero
    localparam logic [7:0] MAIN_CTRL_MASK = 8'ha1;

    // ****************************************************************
    // status register fields
    // ****************************************************************
    localparam int ST_PD_POS = 0;
    localparam int ST_INIT_POS = 1;
    localparam int ST_NORMAL_POS = 2;
    localparam int ST_LINE_PD_POS = 3;
    localparam int ST_PIN_RST_POS = 4;
    localparam int ST_PIN_SLEEP_POS = 5;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 20;
    // least time the internal reset stands once asserted
    localparam int RESET_HOLD_NS = 1000;
    localparam int RESET_HOLD_CYCLES =
        (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_W = 8;

    // ****************************************************************
    // operating states
    // ****************************************************************
    typedef enum logic [1:0] {
        PDRC_POWER_DOWN,
        PDRC_INITIAL,
        PDRC_NORMAL
    } pdrc_state_e;

endpackage

//--- rtl/pdrc_pin_sync.sv
// Purpose: three-stage synchroniser with agreement filter for pin inputs
// Assumes: pins change slowly compared with core_clk
// Notes: the filtered level follows only when stages two and three agree
`timescale 1ns/100ps
module pdrc_pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_q
);

    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    // first stage feeds only the second stage
    always_ff @(posedge core_clk) begin
        if (reset) begin
            s1_q <= INIT;
            s2_q <= INIT;
            s3_q <= INIT;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge core_clk) begin
                if (reset) begin
                    level_q[i] <= INIT[i];
                end else if (s2_q[i] == s3_q[i]) begin
                    level_q[i] <= s3_q[i];
                end
            end
        end
    endgenerate

endmodule // pdrc_pin_sync

//--- verification/pdrc_host_model.sv
// Purpose: host or board logic driving the reset and sleep pins
// Assumes: bench requests come as levels, changed after a clock edge
// Notes: every sleep pin change is followed by an 8-cycle reset pulse
`timescale 1ns/100ps
module pdrc_host_model (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic hold_reset,
    input wire logic sleep_req,
    output logic power_down_reset_n,
    output logic line_codec_sleep
);
    // ****************************************************************
    // pin drivers
    // ****************************************************************
    logic [3:0] pulse_q;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pulse_q <= 4'h0;
            line_codec_sleep <= 1'b0;
        end else if (sleep_req != line_codec_sleep) begin
            line_codec_sleep <= sleep_req;
            pulse_q <= 4'h8;
        end else if (pulse_q != 4'h0) begin
            pulse_q <= pulse_q - 4'h1;
        end
        // pin stays high unless a reset is wanted
        power_down_reset_n <= !(hold_reset || pulse_q != 4'h0);
    end
endmodule // pdrc_host_model

//--- verification/pdrc_top_bench.sv
// Purpose: self-checking bench of the power-down and reset control
// Assumes: HOLD_CYCLES shortened to 4
// Notes: outputs are compared as one packed status vector
`timescale 1ns/100ps
module pdrc_top_bench;
    // ****************************************************************
    // signals
    // ****************************************************************
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic hold_reset = 1'b0;
    logic sleep_req = 1'b0;
    logic power_down_reset_n, line_codec_sleep;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata, outs, rd_val;
    logic core_reset, canceler_clear, initial_mode, normal_mode;
    logic line_codec_power_down, line_codec_out_oe_n;
    logic acoustic_gain_oe_n, line_serial_oe_n;
    int n_fail = 0;
    int compares = 0;

    assign outs = {core_reset, canceler_clear, initial_mode, normal_mode,
        line_codec_power_down, line_codec_out_oe_n, acoustic_gain_oe_n,
        line_serial_oe_n};

    initial begin
        forever #10 core_clk = ~core_clk;
    end

    pdrc_host_model host (.core_clk(core_clk), .reset(reset),
        .hold_reset(hold_reset), .sleep_req(sleep_req),
        .power_down_reset_n(power_down_reset_n),
        .line_codec_sleep(line_codec_sleep));

    pdrc_top #(.HOLD_CYCLES(4)) uut (.core_clk(core_clk), .reset(reset),
        .power_down_reset_n(power_down_reset_n),
        .line_codec_sleep(line_codec_sleep), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .core_reset(core_reset),
        .canceler_clear(canceler_clear), .initial_mode(initial_mode),
        .normal_mode(normal_mode),
        .line_codec_power_down(line_codec_power_down),
        .line_codec_out_oe_n(line_codec_out_oe_n),
        .acoustic_gain_oe_n(acoustic_gain_oe_n),
        .line_serial_oe_n(line_serial_oe_n));

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic give_verdict();
        if (n_fail == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand in the cycle after the strobe only
    task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // waits until the masked output vector reaches the expected bits
    task automatic wait_outs(input logic [7:0] mask, input logic [7:0] v);
        for (int i = 0; i < 300; i++) begin
            @(posedge core_clk);
            #1;
            if ((outs & mask) === v) begin
                return;
            end
        end
        n_fail++;
        give_verdict();
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_start();
        wait_outs(8'h20, 8'h20);
        chk(outs, 8'h21);
        reg_read(pdrc_pkg::STATUS_ADDR, rd_val);
        chk(rd_val, 8'h12);
        @(posedge core_clk);
        #1;
        chk(reg_rdata, 8'h00);
    endtask

    task automatic t_run_and_line_off();
        reg_write(pdrc_pkg::MAIN_CTRL_ADDR, 8'h01);
        wait_outs(8'h10, 8'h10);
        chk(outs, 8'h10);
        reg_write(pdrc_pkg::MAIN_CTRL_ADDR, 8'h21);
        #1;
        chk(outs, 8'h1c);
        reg_write(4'h2, 8'hff);
        reg_read(pdrc_pkg::MAIN_CTRL_ADDR, rd_val);
        chk(rd_val, 8'h21);
        reg_read(4'h5, rd_val);
        chk(rd_val, 8'h00);
        reg_write(pdrc_pkg::MAIN_CTRL_ADDR, 8'h01);
        #1;
        chk(outs, 8'h10);
    endtask

    task automatic t_soft_reset();
        reg_write(pdrc_pkg::MAIN_CTRL_ADDR, 8'h81);
        wait_outs(8'h80, 8'h80);
        chk(outs, 8'hc7);
        reg_read(pdrc_pkg::MAIN_CTRL_ADDR, rd_val);
        chk(rd_val, 8'h00);
        wait_outs(8'h20, 8'h20);
        chk(outs, 8'h21);
    endtask

    task automatic t_pin_reset();
        reg_write(pdrc_pkg::MAIN_CTRL_ADDR, 8'h21);
        wait_outs(8'h10, 8'h10);
        hold_reset <= 1'b1;
        wait_outs(8'h80, 8'h80);
        chk(outs & 8'hf7, 8'hc7);
        reg_read(pdrc_pkg::STATUS_ADDR, rd_val);
        chk(rd_val, 8'h01);
        repeat (10) @(posedge core_clk);
        #1;
        chk(outs & 8'hf7, 8'hc7);
        hold_reset <= 1'b0;
        wait_outs(8'h20, 8'h20);
        chk(outs, 8'h21);
    endtask

    task automatic t_sleep_pin();
        sleep_req <= 1'b1;
        wait_outs(8'h80, 8'h80);
        wait_outs(8'h20, 8'h20);
        chk(outs, 8'h2d);
        reg_read(pdrc_pkg::STATUS_ADDR, rd_val);
        chk(rd_val, 8'h3a);
        sleep_req <= 1'b0;
        wait_outs(8'h80, 8'h80);
        wait_outs(8'h20, 8'h20);
        chk(outs, 8'h21);
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (3) @(posedge core_clk);
        #1;
        chk(outs, 8'hc7);
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        t_start();
        t_run_and_line_off();
        t_soft_reset();
        t_pin_reset();
        t_sleep_pin();
        give_verdict();
    end
endmodule // pdrc_top_bench
